// ==== src/mss_regs.sv ====
// Purpose: Memory size and expansion RAM size select registers
// Assumes: Byte-wide CPU data bus, one-cycle write strobe, 40 MHz clk_i
// Notes:   Size outputs shrink the memory map to match smaller variants
`timescale 1ns/1ps
`default_nettype none
module mss_regs (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // CPU data bus
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             hit_o,
  // Sizes to memory decode
  output logic      [5:0]  rom_kb_o,
  output logic      [10:0] hsram_bytes_o,
  output logic      [10:0] xram_bytes_o,
  output logic             bad_setting_o
);
  // Memory size select register and its next value
  logic [7:0]  mem_size_r;
  logic [7:0]  mem_size_nxt;

  // Expansion RAM size select register and its next value
  logic [7:0]  xram_size_r;
  logic [7:0]  xram_size_nxt;

  // Read data register and its next value
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // ROM capacity register and its next value
  logic [5:0]  rom_kb_r;
  logic [5:0]  rom_kb_nxt;

  // RAM capacity and setting flag registers and their next values
  logic [10:0] hsram_bytes_r;
  logic [10:0] hsram_bytes_nxt;
  logic [10:0] xram_bytes_r;
  logic [10:0] xram_bytes_nxt;
  logic        bad_setting_r;
  logic        bad_setting_nxt;

  // Address selects and qualified strobes
  logic        sel_mem;
  logic        sel_xram;
  logic        wr_mem;
  logic        wr_xram;
  logic        rd_mem;
  logic        rd_xram;

  // Field and capacity carrier to the decoder
  mss_dec_if   dif ();

  // Match of the bus address against one register address
  function automatic logic addr_match(
    input logic [15:0] addr,
    input logic [15:0] reg_addr
  );
    return (addr == reg_addr);
  endfunction

  // Expansion RAM value with its fixed-zero top bits cleared
  function automatic logic [7:0] xram_clean(
    input logic [7:0] value
  );
    return value & mss_pkg::MSS_MASK_XRAM;
  endfunction

  // Read word of the selected register, zero when none is selected
  function automatic logic [7:0] read_word(
    input logic       pick_mem,
    input logic       pick_xram,
    input logic [7:0] mem_value,
    input logic [7:0] xram_value
  );
    logic [7:0] word;
    case ({pick_mem, pick_xram})
      2'b10: begin
        word = mem_value;
      end
      2'b01: begin
        word = xram_clean(xram_value);
      end
      default: begin
        word = 8'h00;
      end
    endcase
    return word;
  endfunction

  // Address decode, shared by write, read and hit
  assign sel_mem  = addr_match(addr_i, mss_pkg::MSS_ADDR_MEM_SIZE);
  assign sel_xram = addr_match(addr_i, mss_pkg::MSS_ADDR_XRAM_SIZE);
  assign hit_o    = sel_mem | sel_xram;

  // Strobes qualified by the selected register
  assign wr_mem   = wr_i & sel_mem;
  assign wr_xram  = wr_i & sel_xram;
  assign rd_mem   = rd_i & sel_mem;
  assign rd_xram  = rd_i & sel_xram;

  // Memory size select next value; bytes are stored as written, so a
  // prohibited pattern reads back unchanged and only the decode flags it
  always_comb begin
    mem_size_nxt = mem_size_r;
    if (wr_mem) begin
      mem_size_nxt = wdata_i;
    end
  end

  // Memory size select register, power-up setting on reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mem_size_r <= mss_pkg::MSS_RST_MEM_SIZE;
    end else begin
      mem_size_r <= mem_size_nxt;
    end
  end

  // Expansion RAM size select next value, top bits never stored
  always_comb begin
    xram_size_nxt = xram_size_r;
    if (wr_xram) begin
      xram_size_nxt = xram_clean(wdata_i);
    end
  end

  // Expansion RAM size select register, zero bytes after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      xram_size_r <= mss_pkg::MSS_RST_XRAM_SIZE;
    end else begin
      xram_size_r <= xram_size_nxt;
    end
  end

  // Read data; a read in the cycle of a write returns the old value
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_i) begin
      rdata_nxt = read_word(rd_mem, rd_xram, mem_size_r, xram_size_r);
    end
  end

  // Read data register, holds until the next read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data to the bus
  assign rdata_o = rdata_r;

  // Fields of the pending values go to the decoder
  assign dif.rom_field   = mem_size_nxt[mss_pkg::MSS_ROM_LSB +: mss_pkg::MSS_ROM_W];
  assign dif.hsram_field = mem_size_nxt[mss_pkg::MSS_HSRAM_LSB +: mss_pkg::MSS_HSRAM_W];
  assign dif.xram_field  = xram_size_nxt[mss_pkg::MSS_XRAM_W-1:0];

  // Capacity decode of the pending register contents
  mss_size_dec u_dec (
    .d (dif.dec)
  );

  // Capacities decoded from the next values land with the registers,
  // so the memory map never lags a write by an extra cycle
  always_comb begin
    rom_kb_nxt = dif.rom_kb;
  end

  // ROM capacity register, full size after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rom_kb_r <= mss_pkg::MSS_KB_60;
    end else begin
      rom_kb_r <= rom_kb_nxt;
    end
  end

  // RAM capacities and setting flag next values
  always_comb begin
    hsram_bytes_nxt = dif.hsram_bytes;
    xram_bytes_nxt  = dif.xram_bytes;
    bad_setting_nxt = dif.bad_setting;
  end

  // RAM capacity and setting flag registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hsram_bytes_r <= mss_pkg::MSS_BYTES_1K;
      xram_bytes_r  <= mss_pkg::MSS_BYTES_0;
      bad_setting_r <= 1'b0;
    end else begin
      hsram_bytes_r <= hsram_bytes_nxt;
      xram_bytes_r  <= xram_bytes_nxt;
      bad_setting_r <= bad_setting_nxt;
    end
  end

  // Shrunk capacities drive the memory decode logic
  assign rom_kb_o      = rom_kb_r;
  assign hsram_bytes_o = hsram_bytes_r;
  assign xram_bytes_o  = xram_bytes_r;
  assign bad_setting_o = bad_setting_r;
endmodule // mss_regs
`default_nettype wire

// ==== src/mss_pkg.sv ====
// Purpose: Shared constants for the memory size switch register bank
// Assumes: 8-bit data bus, 16-bit data addresses
// Notes:   Field positions and decode patterns live here only
package mss_pkg;
  // Register addresses
  localparam logic [15:0] MSS_ADDR_MEM_SIZE  = 16'hFFF0;
  localparam logic [15:0] MSS_ADDR_XRAM_SIZE = 16'hFFF4;
  // Reset values
  localparam logic [7:0]  MSS_RST_MEM_SIZE   = 8'hCF;
  localparam logic [7:0]  MSS_RST_XRAM_SIZE  = 8'h0C;
  // Writable bit masks
  localparam logic [7:0]  MSS_MASK_XRAM      = 8'h1F;
  // Field positions
  localparam int          MSS_HSRAM_LSB      = 5;
  localparam int          MSS_HSRAM_W        = 3;
  localparam int          MSS_ROM_LSB        = 0;
  localparam int          MSS_ROM_W          = 4;
  localparam int          MSS_XRAM_W         = 5;
  // Decode patterns
  localparam logic [2:0]  MSS_HSRAM_1K       = 3'h6;
  localparam logic [3:0]  MSS_ROM_24K        = 4'h6;
  localparam logic [3:0]  MSS_ROM_32K        = 4'h8;
  localparam logic [3:0]  MSS_ROM_48K        = 4'hC;
  localparam logic [3:0]  MSS_ROM_60K        = 4'hF;
  localparam logic [4:0]  MSS_XRAM_0         = 5'h0C;
  localparam logic [4:0]  MSS_XRAM_1K        = 5'h0A;
  // Decoded sizes, in KB for ROM and in bytes for RAM
  localparam logic [5:0]  MSS_KB_24          = 6'h18;
  localparam logic [5:0]  MSS_KB_32          = 6'h20;
  localparam logic [5:0]  MSS_KB_48          = 6'h30;
  localparam logic [5:0]  MSS_KB_60          = 6'h3C;
  localparam logic [10:0] MSS_BYTES_1K       = 11'h400;
  localparam logic [10:0] MSS_BYTES_0        = 11'h000;
endpackage

// ==== src/mss_dec_if.sv ====
// Purpose: Carries raw register fields to the size decoder and sizes back
// Assumes: Single clock domain, purely combinational decode
// Notes:   Modports split the register side from the decoder side
`timescale 1ns/1ps
`default_nettype none
interface mss_dec_if;
  logic [3:0]  rom_field;
  logic [2:0]  hsram_field;
  logic [4:0]  xram_field;
  logic [5:0]  rom_kb;
  logic [10:0] hsram_bytes;
  logic [10:0] xram_bytes;
  logic        bad_setting;
  modport regs (output rom_field, hsram_field, xram_field,
                input  rom_kb, hsram_bytes, xram_bytes, bad_setting);
  modport dec  (input  rom_field, hsram_field, xram_field,
                output rom_kb, hsram_bytes, xram_bytes, bad_setting);
endinterface
`default_nettype wire

// ==== src/mss_size_dec.sv ====
// Purpose: Turns register fields into memory capacities for decode logic
// Assumes: Fields come from the next values of registers on the same clock
// Notes:   Prohibited patterns give zero size and raise bad_setting
`timescale 1ns/1ps
`default_nettype none
module mss_size_dec (
  // Field and size carrier
  mss_dec_if.dec d
);
  // Capacity decode of all three fields
  always_comb begin
    d.bad_setting = 1'b0;
    case (d.rom_field)
      mss_pkg::MSS_ROM_24K: d.rom_kb = mss_pkg::MSS_KB_24;
      mss_pkg::MSS_ROM_32K: d.rom_kb = mss_pkg::MSS_KB_32;
      mss_pkg::MSS_ROM_48K: d.rom_kb = mss_pkg::MSS_KB_48;
      mss_pkg::MSS_ROM_60K: d.rom_kb = mss_pkg::MSS_KB_60;
      default: begin
        d.rom_kb      = 6'h00;
        d.bad_setting = 1'b1;
      end
    endcase
    if (d.hsram_field == mss_pkg::MSS_HSRAM_1K) begin
      d.hsram_bytes = mss_pkg::MSS_BYTES_1K;
    end else begin
      d.hsram_bytes = mss_pkg::MSS_BYTES_0;
      d.bad_setting = 1'b1;
    end
    case (d.xram_field)
      mss_pkg::MSS_XRAM_0:  d.xram_bytes = mss_pkg::MSS_BYTES_0;
      mss_pkg::MSS_XRAM_1K: d.xram_bytes = mss_pkg::MSS_BYTES_1K;
      default: begin
        d.xram_bytes  = mss_pkg::MSS_BYTES_0;
        d.bad_setting = 1'b1;
      end
    endcase
  end
endmodule // mss_size_dec
`default_nettype wire

// ==== dv/mss_regs_checker.sv ====
// Purpose: Port assertions for the size registers
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into mss_regs
`timescale 1ns/1ps
`default_nettype none
module mss_regs_checker (
  input wire logic clk_i, rst_n_i, wr_i, rd_i, hit_o, bad_setting_o,
  input wire logic [15:0] addr_i, input wire logic [7:0] wdata_i, rdata_o,
  input wire logic [5:0] rom_kb_o, input wire logic [10:0] hsram_bytes_o, xram_bytes_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Sizes, map and read-back
  a_reset_mem: assert property ($rose(rst_n_i) |-> rom_kb_o == 6'h3C)
    else $error("rom size after reset");
  a_reset_xram: assert property ($rose(rst_n_i) |-> xram_bytes_o == 11'h000)
    else $error("xram size after reset");
  a_hit_map: assert property (hit_o == (addr_i inside {16'hFFF0, 16'hFFF4}))
    else $error("hit decode");
  a_rom_48k: assert property (wr_i && addr_i == 16'hFFF0 && wdata_i[3:0] == 4'hC |=>
    rom_kb_o == 6'h30) else $error("rom 48 KB");
  a_hsram_size: assert property (wr_i && addr_i == 16'hFFF0 |=> hsram_bytes_o ==
    ($past(wdata_i[7:5]) == 3'h6 ? 11'h400 : 11'h000)) else $error("hsram size");
  a_xram_size: assert property (wr_i && addr_i == 16'hFFF4 |=> xram_bytes_o ==
    ($past(wdata_i[4:0]) == 5'h0A ? 11'h400 : 11'h000)) else $error("xram size");
  a_xram_top: assert property (rd_i && addr_i == 16'hFFF4 |=> rdata_o[7:5] == 3'h0)
    else $error("xram top bits");
  a_sizes_hold: assert property (!wr_i |=> $stable(rom_kb_o) && $stable(xram_bytes_o))
    else $error("size moved");
  cover property (wr_i && addr_i == 16'hFFF4 && wdata_i == 8'h0A);
  cover property (bad_setting_o);
  cover property (rd_i && hit_o);
endmodule // mss_regs_checker
bind mss_regs mss_regs_checker u_chk (.clk_i, .rst_n_i, .wr_i, .rd_i, .hit_o, .bad_setting_o,
  .addr_i, .wdata_i, .rdata_o, .rom_kb_o, .hsram_bytes_o, .xram_bytes_o);
`default_nettype wire

// ==== dv/mss_regs_tb.sv ====
// Purpose: Self-checking bench for the size registers
// Assumes: Inputs change on the falling edge
// Notes:   Expected sizes follow the decode tables
`timescale 1ns/1ps
`default_nettype none
module mss_regs_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, hit_o, bad_setting_o;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [5:0] rom_kb_o;
  logic [10:0] hsram_bytes_o, xram_bytes_o;
  int bad_count = 0, compares = 0;
  // 40 MHz clock and the unit
  always #12.5 clk_i = ~clk_i;
  mss_regs u_dut (.clk_i, .rst_n_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .hit_o, .rom_kb_o, .hsram_bytes_o, .xram_bytes_o, .bad_setting_o);
  // Count a compare, report a mismatch
  task automatic chk(input string n, input logic [10:0] e, s);
    compares++;
    bad_count += int'(s !== e);
    if (s !== e) $display("[ERR] %s expected %h seen %h", n, e, s);
  endtask
  // Compare the three capacity outputs and the setting flag
  task automatic sizes(input logic [5:0] r, input logic [10:0] h, x, input logic b);
    chk("rom_kb", {5'h00, r}, {5'h00, rom_kb_o});
    chk("hsram_bytes", h, hsram_bytes_o);
    chk("xram_bytes", x, xram_bytes_o);
    chk("bad_setting", {10'h000, b}, {10'h000, bad_setting_o});
  endtask
  // One bus cycle; a read is compared with d
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {addr_i, wdata_i, wr_i, rd_i} = {a, d, w, !w};
    @(negedge clk_i);
    {wr_i, rd_i} = 2'b00;
    if (!w) chk("rdata", {3'h0, d}, {3'h0, rdata_o});
  endtask
  // Counts and verdict
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog far past the run
  initial begin
    #20us bad_count++;
    complete_run;
  end
  // Variant settings and the capacities they give
  localparam logic [31:0] mem_sets  = 32'hCFCCC8C6;
  localparam logic [31:0] rom_kbs   = 32'h3C302018;
  localparam logic [15:0] xram_sets = 16'h0A0C;
  localparam logic [21:0] xram_caps = {11'h400, 11'h000};
  // Test sequence
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    sizes(6'h3C, 11'h400, 11'h000, 1'b0);
    acc(1'b0, 16'hFFF0, 8'hCF);
    acc(1'b0, 16'hFFF4, 8'h0C);
    chk("hit", 11'h001, {10'h000, hit_o});
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 16'hFFF0, mem_sets[8*i+:8]);
      acc(1'b0, 16'hFFF0, mem_sets[8*i+:8]);
      sizes(rom_kbs[8*i+:6], 11'h400, 11'h000, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 16'hFFF4, xram_sets[8*i+:8]);
      sizes(6'h3C, 11'h400, xram_caps[11*i+:11], 1'b0);
    end
    acc(1'b0, 16'hFFF4, 8'h0A);
    acc(1'b1, 16'hFFF4, 8'hFF);
    acc(1'b0, 16'hFFF4, 8'h1F);
    sizes(6'h3C, 11'h400, 11'h000, 1'b1);
    acc(1'b1, 16'hFFF4, 8'h0A);
    acc(1'b1, 16'hFFF0, 8'hA5);
    sizes(6'h00, 11'h000, 11'h400, 1'b1);
    acc(1'b0, 16'h1234, 8'h00);
    chk("hit", 11'h000, {10'h000, hit_o});
    acc(1'b1, 16'hFFF1, 8'h00);
    acc(1'b0, 16'hFFF0, 8'hA5);
    // Reset again in mid-run, two cycles long
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("rdata", 11'h000, {3'h0, rdata_o});
    sizes(6'h3C, 11'h400, 11'h000, 1'b0);
    acc(1'b0, 16'hFFF0, 8'hCF);
    acc(1'b0, 16'hFFF4, 8'h0C);
    complete_run;
  end
endmodule // mss_regs_tb
`default_nettype wire
